// ---- rtl/ptsp_params.svh ----
// Constants for the stamp processor and stamp queue: offsets, fields, timing figures
`ifndef PTSP_PARAMS_SVH
`define PTSP_PARAMS_SVH

// Register byte offsets
`define PTSP_OFS_WORD0      8'h00
`define PTSP_OFS_WORD1      8'h04
`define PTSP_OFS_WORD2      8'h08
`define PTSP_OFS_WORD3      8'h0C
`define PTSP_OFS_WORD4      8'h10
`define PTSP_OFS_WORD5      8'h14
`define PTSP_OFS_WORD6      8'h18
`define PTSP_OFS_CONTROL    8'h1C
`define PTSP_OFS_STATUS     8'h20
`define PTSP_OFS_ASYM       8'h24
`define PTSP_OFS_LOCAL_LAT  8'h28
`define PTSP_OFS_PATH_DELAY 8'h2C

// Control register fields
`define PTSP_CTL_SIG_LSB    0
`define PTSP_CTL_SIG_MSB    4
`define PTSP_CTL_SHORT      5
`define PTSP_CTL_SERIAL     6
`define PTSP_CTL_ADD_ASYM   7
`define PTSP_CTL_SUB_ASYM   8
`define PTSP_CTL_THR_ENA    9
`define PTSP_CTL_THR_LSB    16
`define PTSP_CTL_THR_MSB    23
`define PTSP_CTL_RESET      32'h0000_0010

// Status register fields
`define PTSP_ST_LVL_LSB     0
`define PTSP_ST_LVL_MSB     7
`define PTSP_ST_OVF         8

// First queue word fields
`define PTSP_W0_EMPTY       31
`define PTSP_W0_FLG_LSB     16
`define PTSP_W0_FLG_MSB     18

// Sizes in bytes
`define PTSP_SET_BYTES      6'd26
`define PTSP_FULL_STAMP     6'd10
`define PTSP_SHORT_STAMP    6'd4
`define PTSP_MAX_SIG        5'd16

// Flag codes
`define PTSP_FLG_FULL       3'h7
`define PTSP_FLG_MAX_CNT    3'h6

// Time of day
`define PTSP_NS_PER_SEC     33'd1000000000

`endif

// ---- rtl/ptsp_pkg.sv ----
// Types shared by the stamp processor and stamp queue
package ptsp_pkg;

  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] nsec;
  } ptsp_tod_t;

  typedef struct packed {
    logic         egress;
    logic         is_event;
    logic         want_corr;
    logic         save_stamp;
    ptsp_tod_t    raw;
    logic [31:0]  var_latency;
    logic [63:0]  corr_in;
    logic [127:0] signature;
  } ptsp_req_t;

  typedef struct packed {
    logic        is_corr;
    ptsp_tod_t   stamp;
    logic [63:0] corr;
  } ptsp_rewrite_t;

endpackage

// ---- rtl/ptsp_top.sv ----
// Stamp processor with latency compensation and packed egress stamp queue
//
// Behaviour
// - Output either corrected time snapshot or signed 64-bit correction to the rewriter.
// - Ingress subtracts fixed and variable latency from raw stamp; egress adds both.
// - Also provide active stamp in nanoseconds and that plus path delay.
// - Fixed latency from software; variable latency predicted per frame by coding sublayer.
// - Path delay is always added into the produced correction value.
// - Add-asymmetry control adds sign-extended asymmetry setting to the correction.
// - Subtract-asymmetry control, with add-asymmetry clear, subtracts sign-extended asymmetry setting from the correction.
// - Shadow copies of latency, path delay and asymmetry guard calculations in flight.
// - Only event messages are updated; follow-up messages pass unmodified.
// - Stamp queue serves egress frames only; ingress stamps are never stored.
// - Indicate each saved stamp entry, and separately each queue overflow.
// - Save only configured signature bytes; packing makes smaller entries fit more.
// - Uncompressed entry is 208 bits: 128 signature plus 80 stamp.
// - With no signature bytes an entry is 10 bytes, or 4 in short mode.
// - Entries gather in a packing register; 26 bytes are written end to end.
// - Queue read as seven words; word 0 bit 31 is empty, else 16 bits data.
// - Reading the seventh word pops; software reads one set at a time.
// - When reads drain the queue, partial packing register contents are flushed in.
// - Three-bit flags: 0 partial only, 1-6 stamps beginning, 7 fully packed.
// - Maskable alert when fill level reaches threshold; fill level is readable.
// - On overflow further stamps are dropped; stored entries remain readable.
// - Frame signature taken from the analyzer is at most 16 bytes.
// - With serial output enabled, register reads of the queue return invalid data.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ptsp_params.svh"

module ptsp_top
  import ptsp_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  input  wire logic          req_valid,
  input  wire ptsp_req_t     req,
  output logic               rw_valid,
  output ptsp_rewrite_t      rw_data,
  output logic      [63:0]   compensated_stamp_nanos,
  output logic      [63:0]   peer_compensated_stamp_nanos,
  output logic               stamp_saved_pulse,
  output logic               overflow_pulse,
  output logic               fill_alert
);

  localparam int LW = $clog2(DEPTH + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Software registers
  logic [31:0] control_q;
  logic [31:0] asym_q;
  logic [31:0] local_lat_q;
  logic [31:0] path_delay_q;
  logic [31:0] asym_sh_q;
  logic [31:0] local_lat_sh_q;
  logic [31:0] path_delay_sh_q;
  logic        ovf_sticky_q;

  // Pipeline
  logic          s1_valid_q;
  ptsp_req_t     s1_req_q;
  ptsp_tod_t     s1_active_q;

  // Queue
  logic [210:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [LW-1:0] level_q;
  logic [415:0]  pack_q;
  logic [4:0]    fill_q;
  logic [2:0]    starts_q;
  logic          drained_q;

  wire logic       serial_en = control_q[`PTSP_CTL_SERIAL];
  wire logic       q_empty   = (level_q == '0);
  wire logic       q_full    = (level_q == LW'(DEPTH));
  wire logic [7:0] thr       = control_q[`PTSP_CTL_THR_MSB:`PTSP_CTL_THR_LSB];

  // Stage 1: active stamp from raw capture
  logic [32:0] lat_sum;
  logic [32:0] ns_calc;
  ptsp_tod_t   active_d;

  // Latency sum stays below one second, so one carry or borrow is enough
  always_comb begin
    lat_sum  = {1'b0, local_lat_sh_q} + {1'b0, req.var_latency};
    active_d = req.raw;
    if (req.egress) begin
      ns_calc = {1'b0, req.raw.nsec} + lat_sum;
      if (ns_calc >= `PTSP_NS_PER_SEC) begin
        active_d.nsec = 32'(ns_calc - `PTSP_NS_PER_SEC);
        active_d.sec  = req.raw.sec + 48'h1;
      end else begin
        active_d.nsec = ns_calc[31:0];
      end
    end else begin
      ns_calc = {1'b0, req.raw.nsec} - lat_sum;
      if ({1'b0, req.raw.nsec} < lat_sum) begin
        active_d.nsec = 32'(ns_calc + `PTSP_NS_PER_SEC);
        active_d.sec  = req.raw.sec - 48'h1;
      end else begin
        active_d.nsec = ns_calc[31:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1_valid_q  <= 1'b0;
      s1_req_q    <= '0;
      s1_active_q <= '0;
    end else begin
      s1_valid_q  <= req_valid;
      s1_req_q    <= req;
      s1_active_q <= active_d;
    end
  end

  // Shadows only reload while no frame is in flight
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      asym_sh_q       <= '0;
      local_lat_sh_q  <= '0;
      path_delay_sh_q <= '0;
    end else if (!req_valid && !s1_valid_q) begin
      asym_sh_q       <= asym_q;
      local_lat_sh_q  <= local_lat_q;
      path_delay_sh_q <= path_delay_q;
    end
  end

  // Stage 2: nanoseconds, correction, rewrite output
  logic [63:0] nanos_d;
  logic [63:0] resid;
  logic [63:0] asym_ext;
  logic [63:0] corr_d;

  // Asymmetry controls are read live; only the programmed values are shadowed
  always_comb begin
    nanos_d  = 64'(s1_active_q.sec * 64'(`PTSP_NS_PER_SEC)) + {32'h0, s1_active_q.nsec};
    resid    = {16'h0, s1_active_q.nsec, 16'h0};
    asym_ext = {{32{asym_sh_q[31]}}, asym_sh_q};
    corr_d   = s1_req_q.egress ? s1_req_q.corr_in + resid : s1_req_q.corr_in - resid;
    corr_d   = corr_d + {16'h0, path_delay_sh_q, 16'h0};
    if (control_q[`PTSP_CTL_ADD_ASYM]) begin
      corr_d = corr_d + asym_ext;
    end else if (control_q[`PTSP_CTL_SUB_ASYM]) begin
      corr_d = corr_d - asym_ext;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rw_valid                     <= 1'b0;
      rw_data                      <= '0;
      compensated_stamp_nanos      <= '0;
      peer_compensated_stamp_nanos <= '0;
    end else begin
      rw_valid              <= s1_valid_q && s1_req_q.is_event;
      rw_data.is_corr       <= s1_req_q.want_corr;
      rw_data.stamp         <= s1_active_q;
      rw_data.corr          <= corr_d;
      compensated_stamp_nanos      <= nanos_d;
      peer_compensated_stamp_nanos <= nanos_d + {32'h0, path_delay_sh_q};
    end
  end

  // Entry building and packing
  logic [4:0]   sig_n;
  logic [5:0]   ent_len;
  logic [207:0] ent;
  logic [127:0] sig_mask;
  logic [415:0] merged;
  logic [5:0]   total;
  logic         ent_ok;
  logic         need_push;
  logic         flush;
  logic         do_push;
  logic [210:0] push_word;
  logic         pop;

  always_comb begin
    sig_n = control_q[`PTSP_CTL_SIG_MSB:`PTSP_CTL_SIG_LSB];
    if (sig_n > `PTSP_MAX_SIG) begin
      sig_n = `PTSP_MAX_SIG;
    end
    sig_mask = ~(128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF << {sig_n, 3'b000});
    if (control_q[`PTSP_CTL_SHORT] && sig_n == 5'h0) begin
      ent_len = `PTSP_SHORT_STAMP;
      ent     = {176'h0, s1_active_q.nsec};
    end else begin
      ent_len = `PTSP_FULL_STAMP + 6'(sig_n);
      ent     = {s1_req_q.signature & sig_mask, s1_active_q};
    end
    ent_ok    = s1_valid_q && s1_req_q.egress && s1_req_q.is_event
                && s1_req_q.save_stamp;
    total     = 6'(fill_q) + ent_len;
    merged    = pack_q | ({208'h0, ent} << {fill_q, 3'b000});
    need_push = total >= `PTSP_SET_BYTES;
    flush     = !ent_ok && drained_q && q_empty && fill_q != 5'h0;
    do_push   = (ent_ok && need_push && !q_full) || flush;
    // A flushed set carries its begun count; a pushed set is full by definition
    if (flush) begin
      push_word = {starts_q, pack_q[207:0]};
    end else begin
      push_word = {`PTSP_FLG_FULL, merged[207:0]};
    end
    // Pop only on the last word, so a set is read out as one unit
    pop = reg_rd && reg_addr == `PTSP_OFS_WORD6 && !q_empty && !serial_en;
  end

  // A full queue drops the whole of an entry that would complete a set, so none of it enters the packing register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pack_q   <= '0;
      fill_q   <= '0;
      starts_q <= '0;
    end else if (flush) begin
      pack_q   <= '0;
      fill_q   <= '0;
      starts_q <= '0;
    end else if (ent_ok && need_push && q_full) begin
      pack_q   <= pack_q;
    end else if (ent_ok && need_push) begin
      pack_q   <= {208'h0, merged[415:208]};
      fill_q   <= 5'(total - `PTSP_SET_BYTES);
      starts_q <= '0;
    end else if (ent_ok) begin
      pack_q   <= merged;
      fill_q   <= total[4:0];
      starts_q <= (starts_q == `PTSP_FLG_MAX_CNT) ? starts_q : starts_q + 3'h1;
    end
  end

  // Drain marker arms a flush once software has emptied the queue
  // Nothing packed at drain time disarms it: later entries wait for a full set
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      drained_q <= 1'b0;
    end else if (pop && level_q == LW'(1)) begin
      drained_q <= 1'b1;
    end else if (flush || !q_empty || fill_q == 5'h0) begin
      drained_q <= 1'b0;
    end
  end

  // Storage has no reset; the empty flag masks whatever it holds
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr_q] <= push_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      level_q <= level_q + LW'(do_push) - LW'(pop);
    end
  end

  // Event indications
  // Alert lags the level by one cycle; a zero threshold keeps it quiet
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stamp_saved_pulse <= 1'b0;
      overflow_pulse    <= 1'b0;
      fill_alert        <= 1'b0;
    end else begin
      stamp_saved_pulse <= ent_ok && !(need_push && q_full);
      overflow_pulse    <= ent_ok && need_push && q_full;
      fill_alert        <= control_q[`PTSP_CTL_THR_ENA] && thr != 8'h0
                           && 8'(level_q) >= thr;
    end
  end

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      control_q    <= `PTSP_CTL_RESET;
      asym_q       <= '0;
      local_lat_q  <= '0;
      path_delay_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `PTSP_OFS_CONTROL:    control_q    <= reg_wdata;
        `PTSP_OFS_ASYM:       asym_q       <= reg_wdata;
        `PTSP_OFS_LOCAL_LAT:  local_lat_q  <= reg_wdata;
        `PTSP_OFS_PATH_DELAY: path_delay_q <= reg_wdata;
        default:              control_q    <= control_q;
      endcase
    end
  end

  // Overflow sticky: set wins over write-one-to-clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ovf_sticky_q <= 1'b0;
    end else if (ent_ok && need_push && q_full) begin
      ovf_sticky_q <= 1'b1;
    end else if (reg_wr && reg_addr == `PTSP_OFS_STATUS && reg_wdata[`PTSP_ST_OVF]) begin
      ovf_sticky_q <= 1'b0;
    end
  end

  // Register reads, data one cycle later
  logic [210:0] head;
  logic [31:0]  rd_d;
  logic [31:0]  status_w;

  always_comb begin
    head     = mem[rd_ptr_q];
    status_w = '0;
    status_w[`PTSP_ST_LVL_MSB:`PTSP_ST_LVL_LSB] = 8'(level_q);
    status_w[`PTSP_ST_OVF] = ovf_sticky_q;
    rd_d = '0;
    case (reg_addr)
      `PTSP_OFS_WORD0: begin
        rd_d[`PTSP_W0_EMPTY] = q_empty;
        if (!q_empty) begin
          rd_d[`PTSP_W0_FLG_MSB:`PTSP_W0_FLG_LSB] = head[210:208];
          rd_d[15:0] = head[207:192];
        end
      end
      `PTSP_OFS_WORD1:      rd_d = head[191:160];
      `PTSP_OFS_WORD2:      rd_d = head[159:128];
      `PTSP_OFS_WORD3:      rd_d = head[127:96];
      `PTSP_OFS_WORD4:      rd_d = head[95:64];
      `PTSP_OFS_WORD5:      rd_d = head[63:32];
      `PTSP_OFS_WORD6:      rd_d = head[31:0];
      `PTSP_OFS_CONTROL:    rd_d = control_q;
      `PTSP_OFS_STATUS:     rd_d = status_w;
      `PTSP_OFS_ASYM:       rd_d = asym_q;
      `PTSP_OFS_LOCAL_LAT:  rd_d = local_lat_q;
      `PTSP_OFS_PATH_DELAY: rd_d = path_delay_q;
      default:              rd_d = '0;
    endcase
    // Queue words mean nothing while the serial path owns the queue
    if (serial_en && reg_addr <= `PTSP_OFS_WORD6) begin
      rd_d = '0;
    end
    if (q_empty && reg_addr > `PTSP_OFS_WORD0 && reg_addr <= `PTSP_OFS_WORD6) begin
      rd_d = '0;
    end
  end

  // Read data drops to zero outside its cycle, so stray samples show nothing
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// ---- testbench/ptsp_top_asserts.sv ----
// Port checker for the stamp processor
`timescale 1ns/1ps
`include "ptsp_params.svh"
module ptsp_top_asserts
  import ptsp_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic          sys_clk,
  input wire logic          reset_n,
  input wire logic [7:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  input wire logic          req_valid,
  input wire ptsp_req_t     req,
  input wire logic          rw_valid,
  input wire ptsp_rewrite_t rw_data,
  input wire logic [63:0]   compensated_stamp_nanos,
  input wire logic [63:0]   peer_compensated_stamp_nanos,
  input wire logic          stamp_saved_pulse,
  input wire logic          overflow_pulse,
  input wire logic          fill_alert
);
  logic sav_ok;
  logic evt;
  assign sav_ok = req_valid & req.egress & req.is_event & req.save_stamp;
  assign evt    = req_valid & req.is_event;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_evt; req_valid && req.is_event; endsequence
  sequence s_out; ##2 rw_valid; endsequence
  property p_rw_lat; s_evt |-> s_out; endproperty
  a_rw_lat: assert property (p_rw_lat)
    else $error("rewrite pulse missing");
  property p_rw_src; rw_valid |-> $past(evt, 2); endproperty
  a_rw_src: assert property (p_rw_src)
    else $error("rewrite pulse without event");
  property p_kind; rw_valid |-> rw_data.is_corr == $past(req.want_corr, 2); endproperty
  a_kind: assert property (p_kind)
    else $error("wrong output kind");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_ns;
    rw_valid |-> compensated_stamp_nanos ==
      64'(rw_data.stamp.sec) * 64'd1000000000 + 64'(rw_data.stamp.nsec);
  endproperty
  a_ns: assert property (p_ns)
    else $error("nanosecond stamp wrong");
  property p_sav_src; stamp_saved_pulse |-> $past(sav_ok, 2); endproperty
  a_sav_src: assert property (p_sav_src)
    else $error("save without egress event");
  property p_sav_lat; $past(sav_ok, 2) |-> stamp_saved_pulse || overflow_pulse; endproperty
  a_sav_lat: assert property (p_sav_lat)
    else $error("entry neither saved nor dropped");
  property p_ovf; overflow_pulse |-> $past(sav_ok, 2) && !stamp_saved_pulse; endproperty
  a_ovf: assert property (p_ovf)
    else $error("bad overflow indication");
endmodule

bind ptsp_top ptsp_top_asserts #(.DEPTH(DEPTH)) i_ptsp_top_asserts (.sys_clk, .reset_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req, .rw_valid,
  .rw_data, .compensated_stamp_nanos, .peer_compensated_stamp_nanos, .stamp_saved_pulse,
  .overflow_pulse, .fill_alert);

// ---- testbench/ptsp_analyzer_model.sv ----
// Behavioural analyzer issuing stamp requests
`timescale 1ns/1ps
module ptsp_analyzer_model
  import ptsp_pkg::*;
(
  input  wire logic sys_clk,
  output logic      req_valid,
  output ptsp_req_t req
);
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  task automatic send(input ptsp_req_t r);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req       <= r;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    // Stale fields inverted so they never pass for a request
    req       <= ~r;
  endtask
endmodule

// ---- testbench/tb_ptsp_top.sv ----
// Self-checking bench for the stamp processor and queue
`timescale 1ns/1ps
`include "ptsp_params.svh"
module tb_ptsp_top
  import ptsp_pkg::*;
;
  logic          sys_clk;
  logic          reset_n;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [31:0]   reg_rdata;
  logic          req_valid;
  ptsp_req_t     req;
  logic          rw_valid;
  ptsp_rewrite_t rw_data;
  logic [63:0]   nanos;
  logic [63:0]   peer;
  logic          saved;
  logic          ovf;
  logic          fill_alert;
  int            errors;
  int            n_checks;
  int            n_saved;
  int            n_ovf;
  logic [31:0]   set_q [7];
  logic [31:0]   d;

  ptsp_analyzer_model i_ptsp_analyzer_model (.sys_clk(sys_clk), .req_valid(req_valid),
    .req(req));
  ptsp_top #(.DEPTH(2)) i_ptsp_top (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req), .rw_valid(rw_valid),
    .rw_data(rw_data), .compensated_stamp_nanos(nanos), .peer_compensated_stamp_nanos(peer),
    .stamp_saved_pulse(saved), .overflow_pulse(ovf), .fill_alert(fill_alert));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (saved === 1'b1) n_saved <= n_saved + 1;
    if (ovf === 1'b1) n_ovf <= n_ovf + 1;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdset();
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      set_q[i] = d;
    end
  endtask
  function automatic ptsp_req_t mk(input logic eg, ev, sv, wc, input logic [47:0] s,
                                   input logic [31:0] ns, vl);
    mk = '0;
    {mk.egress, mk.is_event, mk.save_stamp, mk.want_corr} = {eg, ev, sv, wc};
    mk.raw       = {s, ns};
    mk.var_latency = vl;
    mk.corr_in   = 64'h0000_0100_0000_0000;
    mk.signature = {8{16'hA5C3}};
  endfunction
  task automatic go(input ptsp_req_t r);
    i_ptsp_analyzer_model.send(r);
    @(posedge sys_clk);
    #1;
  endtask

  task automatic t_regs();
    rd(`PTSP_OFS_CONTROL);
    chk(64'(d), 64'h10);
    wr(`PTSP_OFS_ASYM, 32'hFFFF_8000);
    rd(`PTSP_OFS_ASYM);
    chk(64'(d), 64'hFFFF_8000);
  endtask
  task automatic t_egress();
    wr(`PTSP_OFS_LOCAL_LAT, 32'd100);
    wr(`PTSP_OFS_PATH_DELAY, 32'd50);
    repeat (3) @(posedge sys_clk);
    go(mk(1, 1, 0, 0, 48'd1, 32'd999_999_900, 32'd30));
    chk({rw_data.stamp.sec[31:0], rw_data.stamp.nsec}, {32'd2, 32'd30});
    chk(nanos, 64'd2000000030);
    chk(peer, 64'd2000000080);
    fork
      i_ptsp_analyzer_model.send(mk(1, 1, 0, 0, 48'd1, 32'd999_999_900, 32'd30));
      wr(`PTSP_OFS_PATH_DELAY, 32'd7);
    join
    @(posedge sys_clk);
    #1;
    chk(peer, 64'd2000000080);
    wr(`PTSP_OFS_PATH_DELAY, 32'd50);
  endtask
  task automatic t_corr();
    for (int m = 0; m < 2; m++) begin
      wr(`PTSP_OFS_CONTROL, m ? 32'h110 : 32'h90);
      repeat (3) @(posedge sys_clk);
      go(mk(0, 1, 1, 1, 48'd5, 32'd1000, 32'd30));
      chk(rw_data.corr, 64'h0000_00FF_FCCC_0000 + (m ? 64'h8000 : -64'h8000));
    end
    go(mk(0, 0, 1, 1, 48'd5, 32'd1000, 32'd30));
    chk(64'(rw_valid), 64'h0);
    chk(64'(n_saved), 64'h0);
  endtask
  task automatic t_pack();
    wr(`PTSP_OFS_CONTROL, 32'h20);
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 7; k++) go(mk(1, 1, 1, 0, 48'd0, 32'(65552 * k), 32'd0));
    rd(`PTSP_OFS_STATUS);
    chk(64'(n_saved), 64'd7);
    chk(64'(d[7:0]), 64'h1);
    rdset();
    chk({set_q[0][31], set_q[0][18:0]}, {1'b0, 3'h7, 16'h00C4});
    chk({set_q[5], set_q[6]}, {32'd65652, 32'd100});
    rdset();
    chk({set_q[0][31], set_q[0][18:16], set_q[6][15:0]}, {1'b0, 3'h0, 16'h0006});
    rd(`PTSP_OFS_WORD0);
    chk(64'(d), 64'h8000_0000);
  endtask
  task automatic t_ovf();
    wr(`PTSP_OFS_CONTROL, 32'h0002_0210);
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 3; k++) go(mk(1, 1, 1, 0, 48'd3, 32'(500 + k), 32'd0));
    chk(64'(fill_alert), 64'h1);
    rd(`PTSP_OFS_STATUS);
    chk({32'(n_saved), 32'(n_ovf)}, {32'd9, 32'd1});
    chk(64'(d[8:0]), 64'h102);
    wr(`PTSP_OFS_CONTROL, 32'h0002_0250);
    rd(`PTSP_OFS_WORD0);
    chk(64'(d), 64'h0);
    wr(`PTSP_OFS_CONTROL, 32'h10);
    rdset();
    chk(64'(set_q[6]), 64'd600);
  endtask

  task automatic summarize();
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    reset_n   = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    errors    = 0;
    n_checks  = 0;
    n_saved   = 0;
    n_ovf     = 0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_egress();
    t_corr();
    t_pack();
    t_ovf();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    summarize();
  end
endmodule
